// ### rtl/eccpkg.sv
// Package with register map, field layout and modes of the encoder counter control block.
`default_nettype none
package eccpkg;
    localparam logic [11:0] ECC_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] ECC_INIT_ADDR   = 12'h004;
    localparam logic [11:0] ECC_GEC_ADDR    = 12'h008;
    localparam logic [11:0] ECC_MOD_ADDR    = 12'h00C;
    localparam logic [11:0] ECC_STAT_ADDR   = 12'h010;
    localparam logic [11:0] ECC_POS_ADDR    = 12'h014;
    localparam int          ECC_EN_BIT      = 15;
    localparam int          ECC_SIDL_BIT    = 13;
    localparam int          ECC_MODE_LSB    = 10;
    localparam logic [15:0] ECC_CTRL_MASK   = 16'hBFFF;
    localparam logic [15:0] ECC_CTRL_RESET  = 16'h0000;
    localparam logic [31:0] ECC_POS_RESET   = 32'h0000_0000;
    localparam logic [31:0] ECC_MOD_RESET   = 32'hFFFF_FFFF;
    typedef enum logic [2:0] {
        ECC_MODE_NONE     = 3'b000,
        ECC_MODE_EVERY    = 3'b001,
        ECC_MODE_NEXT     = 3'b010,
        ECC_MODE_FIRST    = 3'b011,
        ECC_MODE_SECOND   = 3'b100,
        ECC_MODE_GEC      = 3'b101,
        ECC_MODE_MODULO   = 3'b110,
        ECC_MODE_RESERVED = 3'b111
    } ecc_mode_t;
    typedef enum logic [1:0] {
        ECC_HS_WAIT_HOME = 2'b00,
        ECC_HS_WAIT_ONE  = 2'b01,
        ECC_HS_WAIT_TWO  = 2'b10,
        ECC_HS_DONE      = 2'b11
    } ecc_home_t;
endpackage
`default_nettype wire

// ### rtl/ecc_home_seq.sv
// Home and index sequencer that decides when an index event loads the position counter.
`default_nettype none
module ecc_home_seq import eccpkg::*; (
    // Clock and reset.
    input  wire logic      ref_clk,
    input  wire logic      reset,
    // Mode and events.
    input  wire ecc_mode_t mode,
    input  wire logic      run,
    input  wire logic      home_evt,
    input  wire logic      index_evt,
    // Load request.
    output logic           load_req
);
    ecc_home_t state_reg;
    ecc_mode_t mode_reg;

    // Sequence state; a mode change restarts the search for home, or for the next index in NEXT mode.
    always_ff @(posedge ref_clk) begin
        mode_reg <= mode;
        if (reset || mode != mode_reg) begin
            state_reg <= (mode == ECC_MODE_NEXT) ? ECC_HS_WAIT_ONE : ECC_HS_WAIT_HOME;
        end else if (run) begin
            case (state_reg)
                ECC_HS_WAIT_HOME: begin
                    if (home_evt && (mode == ECC_MODE_FIRST || mode == ECC_MODE_SECOND)) begin
                        state_reg <= (mode == ECC_MODE_SECOND) ? ECC_HS_WAIT_TWO : ECC_HS_WAIT_ONE;
                    end
                end
                ECC_HS_WAIT_TWO: begin
                    if (index_evt) begin
                        state_reg <= ECC_HS_WAIT_ONE;
                    end
                end
                ECC_HS_WAIT_ONE: begin
                    if (index_evt) begin
                        state_reg <= ECC_HS_DONE;
                    end
                end
                default: state_reg <= state_reg;
            endcase
        end
    end

    // A load happens on the awaited index event only.
    assign load_req = run && index_evt && state_reg == ECC_HS_WAIT_ONE && mode == mode_reg &&
                      (mode == ECC_MODE_NEXT || mode == ECC_MODE_FIRST || mode == ECC_MODE_SECOND);
endmodule
`default_nettype wire

// ### rtl/ecc_apb_slave.sv
// APB slave decode helper giving zero-wait answers and an error for unmapped addresses.
`default_nettype none
module ecc_apb_slave import eccpkg::*; (
    // APB request.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    // Decoded strobes.
    output logic             pready,
    output logic             pslverr,
    output logic             wr_stb,
    output logic             rd_hit
);
    // Map check on the word address.
    function automatic logic mapped(input logic [11:0] a);
        return a == ECC_CTRL_ADDR || a == ECC_INIT_ADDR || a == ECC_GEC_ADDR ||
               a == ECC_MOD_ADDR || a == ECC_STAT_ADDR || a == ECC_POS_ADDR;
    endfunction

    // Every access completes in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr_stb  = psel && penable && pwrite && mapped(paddr);
    assign rd_hit  = mapped(paddr);
endmodule
`default_nettype wire

// ### rtl/ecc_top.sv
// Encoder counter control word with position counter initialization over APB.
//
// Added by the designer: register access over APB and the address map.
`default_nettype none
module ecc_top import eccpkg::*; (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder events, already qualified pulses.
    input  wire logic        count_up,
    input  wire logic        count_down,
    input  wire logic        index_evt,
    input  wire logic        home_evt,
    input  wire logic        idle_mode,
    // Status.
    output logic [31:0]      position,
    output logic             counting
);
    logic [15:0] ctrl_reg;
    logic [31:0] init_reg;
    logic [31:0] gec_reg;
    logic [31:0] mod_reg;
    logic [31:0] pos_reg;
    logic [31:0] pos_next;
    logic        wr_stb;
    logic        rd_hit;
    logic        run;
    logic        load_req;
    ecc_mode_t   mode;

    // Bus decode.
    ecc_apb_slave u_apb (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .pslverr (pslverr),
        .wr_stb  (wr_stb),
        .rd_hit  (rd_hit)
    );

    // Software registers, writable whatever the enable state.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_reg <= ECC_CTRL_RESET;
            init_reg <= ECC_POS_RESET;
            gec_reg  <= ECC_POS_RESET;
            mod_reg  <= ECC_MOD_RESET;
        end else if (wr_stb) begin
            case (paddr)
                ECC_CTRL_ADDR: ctrl_reg <= pwdata[15:0] & ECC_CTRL_MASK;
                ECC_INIT_ADDR: init_reg <= pwdata;
                ECC_GEC_ADDR:  gec_reg  <= pwdata;
                ECC_MOD_ADDR:  mod_reg  <= pwdata;
                default:       ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Mode field and run qualification.
    assign mode = ecc_mode_t'(ctrl_reg[ECC_MODE_LSB +: 3]);
    assign run  = ctrl_reg[ECC_EN_BIT] && !(ctrl_reg[ECC_SIDL_BIT] && idle_mode);

    // Index sequencing for the load modes.
    ecc_home_seq u_seq (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .mode      (mode),
        .run       (run),
        .home_evt  (home_evt),
        .index_evt (index_evt),
        .load_req  (load_req)
    );

    // Position counter next value by priority: load, reset, then count.
    always_comb begin
        pos_next = pos_reg;
        if (!run) begin
            pos_next = pos_reg;
        end else if (load_req) begin
            pos_next = init_reg;
        end else if (mode == ECC_MODE_EVERY && index_evt) begin
            pos_next = ECC_POS_RESET;
        end else if (mode == ECC_MODE_GEC && pos_reg == gec_reg) begin
            pos_next = ECC_POS_RESET;
        end else if (count_up && !count_down) begin
            if (mode == ECC_MODE_MODULO && pos_reg == mod_reg) begin
                pos_next = ECC_POS_RESET;
            end else begin
                pos_next = pos_reg + 32'h0000_0001;
            end
        end else if (count_down && !count_up) begin
            if (mode == ECC_MODE_MODULO && pos_reg == ECC_POS_RESET) begin
                pos_next = mod_reg;
            end else begin
                pos_next = pos_reg - 32'h0000_0001;
            end
        end
        // Reserved code leaves only counting active.
    end

    // Position register.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pos_reg <= ECC_POS_RESET;
        end else begin
            pos_reg <= pos_next;
        end
    end

    // Registered read data.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite && rd_hit) begin
            case (paddr)
                ECC_CTRL_ADDR: prdata <= {16'h0000, ctrl_reg};
                ECC_INIT_ADDR: prdata <= init_reg;
                ECC_GEC_ADDR:  prdata <= gec_reg;
                ECC_MOD_ADDR:  prdata <= mod_reg;
                ECC_STAT_ADDR: prdata <= {31'h0000_0000, run};
                default:       prdata <= pos_reg;
            endcase
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
        end
    end

    assign position = pos_reg;
    assign counting = run;

    // Halted counter holds its value.
    halt_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        !run |=> pos_reg == $past(pos_reg)) else $error("counter moved while halted");
    // Idle stop halts.
    idle_stop_a: assert property (@(posedge ref_clk) disable iff (reset)
        ctrl_reg[ECC_SIDL_BIT] && idle_mode |-> !run) else $error("ran in idle");
    // Enable bit gates running.
    enable_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
        !ctrl_reg[ECC_EN_BIT] |-> !counting) else $error("counting while disabled");
    // Every index reset.
    index_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
        run && mode == ECC_MODE_EVERY && index_evt |=> pos_reg == 32'h0000_0000)
        else $error("index did not reset");
    // Compare reset.
    gec_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
        run && mode == ECC_MODE_GEC && pos_reg == gec_reg && !load_req |=> pos_reg == 32'h0000_0000)
        else $error("compare did not reset");
    // Load takes init value.
    init_load_a: assert property (@(posedge ref_clk) disable iff (reset)
        load_req |=> pos_reg == $past(init_reg)) else $error("load missed init value");
    // Modulo wrap up.
    modulo_wrap_a: assert property (@(posedge ref_clk) disable iff (reset)
        run && mode == ECC_MODE_MODULO && !load_req && count_up && !count_down && pos_reg == mod_reg
        |=> pos_reg == 32'h0000_0000) else $error("modulo wrap failed");
    // Reserved code never loads.
    reserved_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
        mode == ECC_MODE_RESERVED |-> !load_req) else $error("reserved mode loaded");
    // Write reaches control word.
    ctrl_write_a: assert property (@(posedge ref_clk) disable iff (reset)
        wr_stb && paddr == ECC_CTRL_ADDR |=> ctrl_reg == ($past(pwdata[15:0]) & ECC_CTRL_MASK))
        else $error("control write lost");

    // A clean single up pulse while running, with no event mode active.
    sequence plain_up_s;
        run && mode == ECC_MODE_NONE && count_up && !count_down;
    endsequence

    // A clean single down pulse while running, with no event mode active.
    sequence plain_down_s;
        run && mode == ECC_MODE_NONE && count_down && !count_up;
    endsequence

    // Enabled counter steps up by one.
    count_up_a: assert property (@(posedge ref_clk) disable iff (reset)
        plain_up_s |=> pos_reg == $past(pos_reg) + 32'h0000_0001)
        else $error("up step missed");
    // Enabled counter steps down by one.
    count_down_a: assert property (@(posedge ref_clk) disable iff (reset)
        plain_down_s |=> pos_reg == $past(pos_reg) - 32'h0000_0001)
        else $error("down step missed");
    // Modulo wrap below zero goes to the upper bound.
    modulo_under_a: assert property (@(posedge ref_clk) disable iff (reset)
        run && mode == ECC_MODE_MODULO && count_down && !count_up && pos_reg == ECC_POS_RESET
        |=> pos_reg == $past(mod_reg)) else $error("modulo underflow wrap failed");
    // Reserved code leaves the counter alone without count pulses.
    reserved_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        run && mode == ECC_MODE_RESERVED && !count_up && !count_down
        |=> pos_reg == $past(pos_reg)) else $error("reserved mode moved counter");
    // Enabled with idle stop clear means running.
    idle_run_a: assert property (@(posedge ref_clk) disable iff (reset)
        ctrl_reg[ECC_EN_BIT] && !ctrl_reg[ECC_SIDL_BIT] |-> run)
        else $error("enabled counter not running");
endmodule
`default_nettype wire

// ### dv/ecc_enc_model.sv
// Incremental encoder model driving qualified count, index and home pulses.
`default_nettype none
module ecc_enc_model (
    // Clock.
    input  wire logic ref_clk,
    // Encoder pulses.
    output logic      count_up,
    output logic      count_down,
    output logic      index_evt,
    output logic      home_evt
);
    timeunit 1ns;
    timeprecision 100ps;
    // All pulse lines rest low between events.
    initial {count_up, count_down, index_evt, home_evt} = 4'h0;
    // Sends n one-cycle pulses of one kind, each followed by a quiet cycle.
    task automatic pulse(input logic [3:0] kind, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            {count_up, count_down, index_evt, home_evt} <= kind;
            @(posedge ref_clk);
            {count_up, count_down, index_evt, home_evt} <= 4'h0;
        end
    endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Testbench for the encoder counter control block over APB.
`default_nettype none
module testbench import eccpkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] INIT_V = 32'h1234_5678;
    logic        ref_clk     = 1'b0;
    logic        reset       = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic        idle_mode   = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] position;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        counting;
    logic        err;
    wire logic   count_up;
    wire logic   count_down;
    wire logic   index_evt;
    wire logic   home_evt;
    int          mismatches  = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    // Clock at 200 MHz.
    always #2.5 ref_clk = ~ref_clk;
    ecc_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_up(count_up), .count_down(count_down), .index_evt(index_evt), .home_evt(home_evt),
        .idle_mode(idle_mode), .position(position), .counting(counting));
    ecc_enc_model enc (.ref_clk(ref_clk), .count_up(count_up), .count_down(count_down),
        .index_evt(index_evt), .home_evt(home_evt));
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Compares a value, flags widened to 32 bits.
    task automatic compare32(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // One APB transfer; holds the request until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask
    task automatic rdchk(input logic [11:0] addr, input logic [31:0] want);
        apb(1'b0, addr, 32'h0000_0000);
        compare32(rd, want);
    endtask
    // Checks the position once the last event has landed.
    task automatic pos_chk(input logic [31:0] want);
        repeat (2) @(negedge ref_clk);
        compare32(position, want);
    endtask
    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    // Main sequence.
    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        rdchk(ECC_CTRL_ADDR, {16'h0000, ECC_CTRL_RESET});
        compare32(position, ECC_POS_RESET);
        rdchk(12'h020, 32'h0000_0000);
        compare32({31'h0, err}, 32'h0000_0001);
        wr(ECC_CTRL_ADDR, 32'hFFFF_7FFF);
        rdchk(ECC_CTRL_ADDR, 32'h0000_3FFF);
        enc.pulse(4'h8, 3);
        pos_chk(32'h0000_0000);
        wr(ECC_INIT_ADDR, INIT_V);
        rdchk(ECC_INIT_ADDR, INIT_V);
        wr(ECC_CTRL_ADDR, 32'h0000_8000);
        enc.pulse(4'h8, 5);
        enc.pulse(4'h4, 2);
        enc.pulse(4'h2, 1);
        pos_chk(32'h0000_0003);
        wr(ECC_CTRL_ADDR, 32'h0000_A000);
        idle_mode <= 1'b1;
        enc.pulse(4'h8, 2);
        pos_chk(32'h0000_0003);
        compare32({31'h0, counting}, 32'h0000_0000);
        wr(ECC_CTRL_ADDR, 32'h0000_8000);
        enc.pulse(4'h8, 1);
        pos_chk(32'h0000_0004);
        idle_mode <= 1'b0;
        wr(ECC_CTRL_ADDR, 32'h0000_8800);
        enc.pulse(4'h8, 1);
        enc.pulse(4'h2, 1);
        pos_chk(INIT_V);
        wr(ECC_CTRL_ADDR, 32'h0000_9C00);
        enc.pulse(4'h1, 1);
        enc.pulse(4'h2, 1);
        enc.pulse(4'h8, 1);
        pos_chk(INIT_V + 32'h1);
        wr(ECC_CTRL_ADDR, 32'h0000_8C00);
        enc.pulse(4'h2, 1);
        pos_chk(INIT_V + 32'h1);
        enc.pulse(4'h1, 1);
        enc.pulse(4'h2, 1);
        pos_chk(INIT_V);
        wr(ECC_CTRL_ADDR, 32'h0000_9000);
        enc.pulse(4'h1, 1);
        enc.pulse(4'h2, 1);
        enc.pulse(4'h8, 1);
        pos_chk(INIT_V + 32'h1);
        enc.pulse(4'h2, 1);
        pos_chk(INIT_V);
        wr(ECC_CTRL_ADDR, 32'h0000_8400);
        enc.pulse(4'h8, 2);
        enc.pulse(4'h2, 1);
        pos_chk(32'h0000_0000);
        wr(ECC_GEC_ADDR, 32'h0000_0005);
        wr(ECC_CTRL_ADDR, 32'h0000_9400);
        enc.pulse(4'h8, 4);
        pos_chk(32'h0000_0004);
        enc.pulse(4'h8, 1);
        pos_chk(32'h0000_0000);
        wr(ECC_MOD_ADDR, 32'h0000_0003);
        wr(ECC_CTRL_ADDR, 32'h0000_9800);
        enc.pulse(4'h8, 5);
        pos_chk(32'h0000_0001);
        enc.pulse(4'h4, 2);
        pos_chk(32'h0000_0003);
        rdchk(ECC_POS_ADDR, 32'h0000_0003);
        rdchk(ECC_MOD_ADDR, 32'h0000_0003);
        rdchk(ECC_STAT_ADDR, 32'h0000_0001);
        conclude();
    end
endmodule
`default_nettype wire
